/* File: hdl/codec_pkg.sv */
/*
 * shared constants and types for the companding sample codec.
 * assumes linear samples are 14-bit two's complement in normalized units.
 */
package codec_pkg;

	// ------------------------------------------------------------
	// widths and depths
	// ------------------------------------------------------------
	localparam int LIN_W      = 14;
	localparam int CHR_W      = 8;
	localparam int FIFO_DEPTH = 4;

	// ------------------------------------------------------------
	// law selection
	// ------------------------------------------------------------
	typedef enum logic {
		LAW_A  = 1'b0,
		LAW_MU = 1'b1
	} law_e;

	// ------------------------------------------------------------
	// character layout and scale end points
	// ------------------------------------------------------------
	localparam int                SIGN_POS       = 7;
	localparam logic [CHR_W-1:0]  ALAW_EVEN_INV  = 8'h55;
	localparam logic [LIN_W-1:0]  ALAW_FULL      = 14'h1000;
	localparam logic [LIN_W-1:0]  ALAW_MAX_MAG   = 14'h0fff;
	localparam logic [LIN_W-1:0]  MULAW_FULL     = 14'h1fdf;
	localparam logic [LIN_W-1:0]  MULAW_MAX_MAG  = 14'h1fde;
	localparam logic [LIN_W-1:0]  MULAW_BIAS     = 14'h0021;
	localparam logic [3:0]        ALAW_SEG_MSB   = 4'h4;
	localparam logic [3:0]        MULAW_SEG_MSB  = 4'h5;
	localparam logic [LIN_W-1:0]  SEG_LEAD       = 14'h0010;

	// ------------------------------------------------------------
	// reset value of control state
	// ------------------------------------------------------------
	localparam logic              RST_LEVEL      = 1'b0;

endpackage : codec_pkg

/* File: hdl/stream_if.sv */
/*
 * valid/ready word stream between the codec's own modules.
 * assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

/* File: hdl/char_fifo.sv */
/*
 * shift-register fifo; the head always sits in slot 0 so it leaves a flop.
 * assumes a synchronous active-high reset and one clock.
 */
`timescale 1ns/100ps
`default_nettype none

module char_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// fill and drain sides
	stream_if.snk     fill,
	stream_if.src     drain
);
	import codec_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0]        vld;
		logic [DEPTH-1:0][W-1:0] mem;
	} fifo_s;

	fifo_s q_ff;
	fifo_s nxt_q;
	logic  done;

	// ------------------------------------------------------------
	// ports from flops
	// ------------------------------------------------------------
	// full while popping still refuses; costs a slot, saves a comb path
	assign fill.ready  = ~q_ff.vld[DEPTH-1];
	assign drain.valid = q_ff.vld[0];
	assign drain.data  = q_ff.mem[0];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		done  = 1'b0;
		nxt_q = q_ff;
		if (q_ff.vld[0] && drain.ready) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				nxt_q.mem[i] = q_ff.mem[i+1];
				nxt_q.vld[i] = q_ff.vld[i+1];
			end
			nxt_q.vld[DEPTH-1] = 1'b0;
		end
		if (fill.valid && ~q_ff.vld[DEPTH-1]) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!nxt_q.vld[i] && !done) begin
					nxt_q.mem[i] = fill.data;
					nxt_q.vld[i] = 1'b1;
					done         = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

endmodule : char_fifo

`default_nettype wire

/* File: hdl/companding_sample_codec.sv */
/*
 * companding encoder and decoder, a-law or mu-law, between linear samples
 * and 8-bit characters; encoded characters queue in a small fifo.
 * assumes samples arrive synchronous to ref_clk and law_mu_sel is a level
 * set by the surrounding configuration logic.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: a-law characters have even bit positions complemented; decode undoes it.
// R2: positive a-law input in interval n gives raw code 128 plus n.
// R3: a-law decode returns the midpoint of interval n, n zero to 127.
// R4: a-law magnitude scale ends at 4096 units.
// R5: top character bit is 0 for negative samples, 1 for positive.
// R6: positive mu-law input in interval n gives code 255 minus n.
// R7: mu-law decode gives zero for interval 0, midpoints above.
// R8: mu-law magnitude scale ends at 8159 units, top boundary virtual.
// R9: mu-law uses eight segments; first 1x1 plus 15x2, then doubling sizes.
// R10: selected law applies consistently to each character in both directions.
module companding_sample_codec (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	// configuration
	input  wire logic                          law_mu_sel,
	// linear samples to encode
	input  wire logic                          lin_in_valid,
	input  wire logic [codec_pkg::LIN_W-1:0]   lin_in_data,
	output logic                               lin_in_ready,
	// encoded characters out
	output logic                               chr_out_valid,
	output logic [codec_pkg::CHR_W-1:0]        chr_out_data,
	input  wire logic                          chr_out_ready,
	// characters to decode
	input  wire logic                          chr_in_valid,
	input  wire logic [codec_pkg::CHR_W-1:0]   chr_in_data,
	output logic                               chr_in_ready,
	// decoded linear samples out
	output logic                               lin_out_valid,
	output logic [codec_pkg::LIN_W-1:0]        lin_out_data,
	input  wire logic                          lin_out_ready
);
	import codec_pkg::*;

	typedef struct packed {
		logic             enc_rdy;
		logic             stg_vld;
		logic [CHR_W-1:0] stg_code;
		logic             dec_rdy;
		logic             out_vld;
		logic [LIN_W-1:0] out_lin;
	} state_s;

	state_s st_ff;
	state_s nxt_st;

	stream_if #(.W(CHR_W)) enc_q_in ();
	stream_if #(.W(CHR_W)) enc_q_out ();

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [LIN_W-1:0] mag_of(input logic [LIN_W-1:0] x,
			input logic [LIN_W-1:0] lim);
		logic [LIN_W-1:0] a;
		a = x[LIN_W-1] ? LIN_W'(-x) : x;
		return (a > lim) ? lim : a;
	endfunction : mag_of

	function automatic logic [3:0] msb_pos(input logic [LIN_W-1:0] v);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < LIN_W; i++) begin
			if (v[i]) begin
				p = 4'(i);
			end
		end
		return p;
	endfunction : msb_pos

	// R5: sign from input msb
	// R4: clamp to scale end
	// R2: raw code 128 plus n
	// R1: even bits inverted
	function automatic logic [CHR_W-1:0] alaw_enc(input logic [LIN_W-1:0] x);
		logic [LIN_W-1:0] m;
		logic [3:0]       p;
		logic [2:0]       seg;
		logic [3:0]       sh;
		m   = mag_of(x, ALAW_MAX_MAG);
		p   = msb_pos(m);
		seg = (p <= ALAW_SEG_MSB) ? 3'h0 : 3'(p - ALAW_SEG_MSB);
		sh  = (seg == 3'h0) ? 4'h1 : {1'b0, seg};
		return {~x[LIN_W-1], seg, 4'(m >> sh)} ^ ALAW_EVEN_INV;
	endfunction : alaw_enc

	// R8: clamp below virtual top
	// R9: bias puts segment edges on powers of two
	// R6: code 255 minus n
	function automatic logic [CHR_W-1:0] mulaw_enc(input logic [LIN_W-1:0] x);
		logic [LIN_W-1:0] v;
		logic [2:0]       seg;
		v   = mag_of(x, MULAW_MAX_MAG) + MULAW_BIAS;
		seg = 3'(msb_pos(v) - MULAW_SEG_MSB);
		// shift amount widened; a 3-bit sum wraps in the top segment
		return {~x[LIN_W-1], ~seg, ~4'(v >> ({1'b0, seg} + 4'h1))};
	endfunction : mulaw_enc

	// R1: complement removed first
	// R3: midpoint of bounding decisions
	function automatic logic [LIN_W-1:0] alaw_dec(input logic [CHR_W-1:0] c);
		logic [CHR_W-1:0] r;
		logic [2:0]       seg;
		logic [3:0]       sh;
		logic [LIN_W-1:0] y;
		r   = c ^ ALAW_EVEN_INV;
		seg = r[6:4];
		sh  = (seg == 3'h0) ? 4'h1 : {1'b0, seg};
		y   = (LIN_W'({(seg != 3'h0), r[3:0]}) << sh) + (14'h0001 << (sh - 4'h1));
		return r[SIGN_POS] ? y : LIN_W'(-y);
	endfunction : alaw_dec

	// R7: interval 0 exact zero
	function automatic logic [LIN_W-1:0] mulaw_dec(input logic [CHR_W-1:0] c);
		logic [6:0]       n;
		logic [LIN_W-1:0] y;
		n = ~c[6:0];
		y = LIN_W'((SEG_LEAD + n[3:0]) << ({1'b0, n[6:4]} + 4'h1)) - MULAW_BIAS
			+ LIN_W'(14'h0001 << n[6:4]);
		if (n == 7'h00) begin
			y = '0;
		end
		return c[SIGN_POS] ? y : LIN_W'(-y);
	endfunction : mulaw_dec

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (st_ff.stg_vld && enc_q_in.ready) begin
			nxt_st.stg_vld = 1'b0;
		end
		// R10: law sampled with each sample
		if (lin_in_valid && st_ff.enc_rdy) begin
			nxt_st.stg_vld  = 1'b1;
			nxt_st.stg_code = (law_e'(law_mu_sel) == LAW_MU) ? mulaw_enc(lin_in_data)
				: alaw_enc(lin_in_data);
		end
		// one sample every other cycle at most; voice rates never notice
		nxt_st.enc_rdy = ~nxt_st.stg_vld;
		if (st_ff.out_vld && lin_out_ready) begin
			nxt_st.out_vld = 1'b0;
		end
		// R10: law sampled with each character
		if (chr_in_valid && st_ff.dec_rdy) begin
			nxt_st.out_vld = 1'b1;
			nxt_st.out_lin = (law_e'(law_mu_sel) == LAW_MU) ? mulaw_dec(chr_in_data)
				: alaw_dec(chr_in_data);
		end
		nxt_st.dec_rdy = ~nxt_st.out_vld;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_ff <= {$bits(state_s){RST_LEVEL}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// queue and ports
	// ------------------------------------------------------------
	assign enc_q_in.valid  = st_ff.stg_vld;
	assign enc_q_in.data   = st_ff.stg_code;
	assign enc_q_out.ready = chr_out_ready;

	char_fifo #(.W(CHR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.fill    (enc_q_in),
		.drain   (enc_q_out)
	);

	assign lin_in_ready  = st_ff.enc_rdy;
	assign chr_out_valid = enc_q_out.valid;
	assign chr_out_data  = enc_q_out.data;
	assign chr_in_ready  = st_ff.dec_rdy;
	assign lin_out_valid = st_ff.out_vld;
	assign lin_out_data  = st_ff.out_lin;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic acc_e;
	logic acc_d;
	assign acc_e = lin_in_valid && st_ff.enc_rdy;
	assign acc_d = chr_in_valid && st_ff.dec_rdy;

	alaw_zero_a: assert property (acc_e && !law_mu_sel && lin_in_data == 14'h0000 // R1
		|=> st_ff.stg_vld && st_ff.stg_code == 8'hd5) else $error("a-law zero code wrong");
	alaw_step_a: assert property (acc_e && !law_mu_sel && lin_in_data == 14'h0800 // R2
		|=> st_ff.stg_code == 8'ha5) else $error("a-law interval 112 code wrong");
	alaw_full_a: assert property (acc_e && !law_mu_sel && lin_in_data == 14'h0fff // R4
		|=> st_ff.stg_code == 8'haa) else $error("a-law full scale code wrong");
	sign_bit_a: assert property (acc_e // R5
		|=> st_ff.stg_code[SIGN_POS] == !$past(lin_in_data[LIN_W-1]))
		else $error("sign bit wrong");
	mulaw_zero_a: assert property (acc_e && law_mu_sel && lin_in_data == 14'h0000 // R6
		|=> st_ff.stg_code == 8'hff) else $error("mu-law zero code wrong");
	mulaw_full_a: assert property (acc_e && law_mu_sel && lin_in_data == 14'h1fde // R8
		|=> st_ff.stg_code == 8'h80) else $error("mu-law full scale code wrong");
	mulaw_seg_a: assert property (acc_e && law_mu_sel && lin_in_data == 14'h001f // R9
		|=> st_ff.stg_code == 8'hef) else $error("mu-law segment edge wrong");
	alaw_dec_a: assert property (acc_d && !law_mu_sel && chr_in_data == 8'haa // R3
		|=> lin_out_valid && lin_out_data == 14'h0fc0 [*1] ##1 1)
		else $error("a-law top midpoint wrong");
	mulaw_dec_a: assert property (acc_d && law_mu_sel && chr_in_data == 8'hff // R7
		|=> lin_out_valid && lin_out_data == 14'h0000) else $error("mu-law zero decode wrong");
	mulaw_top_a: assert property (acc_d && law_mu_sel && chr_in_data == 8'h80 // R7
		|=> lin_out_data == 14'h1f5f) else $error("mu-law top midpoint wrong");
	stage_hold_a: assert property (st_ff.stg_vld && !enc_q_in.ready // R10
		|=> st_ff.stg_vld && $stable(st_ff.stg_code)) else $error("held code changed");
	out_hold_a: assert property (chr_out_valid && !chr_out_ready
		|=> chr_out_valid && $stable(chr_out_data)) else $error("queued char dropped");

	fifo_full_c: cover property (st_ff.stg_vld && !enc_q_in.ready);
	mu_dec_c: cover property (acc_d && law_mu_sel ##1 lin_out_valid && lin_out_ready);
	a_enc_c: cover property (acc_e && !law_mu_sel ##[1:8] chr_out_valid && chr_out_ready);

endmodule : companding_sample_codec

`default_nettype wire

/* File: sim/pcm_slot_sink.sv */
/*
 * far-side character sink, paced prompt, random or halted.
 * assumes the codec's clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module pcm_slot_sink (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// character stream
	input  wire logic       chr_valid,
	output logic            chr_ready,
	// pacing: 0 prompt, 1 random, 2 halt
	input  wire logic [1:0] pace
);
	logic [15:0] rnd_ff;

	// slot timing is not ours to know, so pacing is arbitrary
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rnd_ff <= 16'h001f;
		end else begin
			rnd_ff <= {rnd_ff[14:0], rnd_ff[15] ^ rnd_ff[13] ^ rnd_ff[12] ^ rnd_ff[10]};
		end
		chr_ready <= !rst && (pace == 2'h0 || (pace == 2'h1 && rnd_ff[0]));
	end
endmodule : pcm_slot_sink

`default_nettype wire

/* File: sim/companding_sample_codec_tb_top.sv */
/*
 * self-checking bench: integer reference of both laws, queues of expectations.
 * assumes the codec, its fifo and the sink model are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module companding_sample_codec_tb_top;
	import codec_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic             ref_clk = 1'b0;
	logic             rst = 1'b1;
	logic             law_mu_sel = 1'b0;
	logic             lin_in_valid = 1'b0;
	logic [LIN_W-1:0] lin_in_data = 14'h0000;
	logic             chr_in_valid = 1'b0;
	logic [CHR_W-1:0] chr_in_data = 8'h00;
	logic             lin_out_ready = 1'b0;
	logic [1:0]       pace = 2'h0;
	logic             lin_in_ready, chr_out_valid, chr_out_ready;
	logic             chr_in_ready, lin_out_valid;
	logic [CHR_W-1:0] chr_out_data;
	logic [LIN_W-1:0] lin_out_data;
	logic [15:0]      rnd = 16'h001f;
	int               bad_count = 0;
	int               cmp_count = 0;
	int               cyc = 0;
	logic [CHR_W-1:0] enc_q[$];
	logic [LIN_W-1:0] dec_q[$];
	int               vals[10] = '{0, 1, -1, 31, 64, 2048, 4095, 8158, 8191, -8192};

	companding_sample_codec u_dut (.ref_clk(ref_clk), .rst(rst), .law_mu_sel(law_mu_sel),
		.lin_in_valid(lin_in_valid), .lin_in_data(lin_in_data), .lin_in_ready(lin_in_ready),
		.chr_out_valid(chr_out_valid), .chr_out_data(chr_out_data),
		.chr_out_ready(chr_out_ready), .chr_in_valid(chr_in_valid),
		.chr_in_data(chr_in_data), .chr_in_ready(chr_in_ready),
		.lin_out_valid(lin_out_valid), .lin_out_data(lin_out_data),
		.lin_out_ready(lin_out_ready));
	pcm_slot_sink u_sink (.ref_clk(ref_clk), .rst(rst), .chr_valid(chr_out_valid),
		.chr_ready(chr_out_ready), .pace(pace));

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic int log2i(input int v);
		int e = 0;
		while ((v >> (e + 1)) != 0) e++;
		return e;
	endfunction : log2i

	function automatic logic [7:0] enc(input int x, input logic mu);
		int m, n, e, v;
		m = (x < 0) ? -x : x;
		if (mu) begin
			v = ((m > 8158) ? 8158 : m) + 33;
			e = log2i(v);
			n = 16 * (e - 5) + ((v - (1 << e)) >> (e - 4));
			return {x >= 0, ~n[6:0]};
		end
		m = (m > 4095) ? 4095 : m;
		e = log2i(m);
		n = (m < 64) ? m / 2 : 16 * (e - 4) + ((m - (1 << e)) >> (e - 4));
		return {x >= 0, n[6:0]} ^ ALAW_EVEN_INV;
	endfunction : enc

	function automatic logic [13:0] dec(input logic [7:0] c, input logic mu);
		int n, e, y;
		if (!mu) c = c ^ ALAW_EVEN_INV;
		n = c[6:0];
		if (mu) n = 127 - n;
		e = n / 16 + (mu ? 5 : 4);
		y = (1 << e) + (n % 16) * (1 << (e - 4)) + (1 << (e - 5));
		if (mu) y = (n == 0) ? 0 : y - 33;
		else if (n < 32) y = 2 * n + 1;
		return 14'(c[7] ? y : -y);
	endfunction : dec

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	// outputs are flops, so values before the edge are settled here
	always @(negedge ref_clk) begin
		if (!rst && chr_out_valid === 1'b1 && chr_out_ready === 1'b1) begin
			check("chr_out_data", chr_out_data, enc_q.pop_front());
		end
		if (!rst && lin_out_valid === 1'b1 && lin_out_ready === 1'b1) begin
			check("lin_out_data", lin_out_data, dec_q.pop_front());
		end
	end

	always @(posedge ref_clk) begin
		cyc++;
		lin_out_ready <= (cyc % 3) != 0;
		if (cyc > 20000) begin
			bad_count++;
			finish_test();
		end
	end

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	// valid stays up on return; the caller lowers it after the last one
	task automatic send_lin(input logic [13:0] x, input logic mu);
		lin_in_valid <= 1'b1;
		lin_in_data <= x;
		law_mu_sel <= mu;
		enc_q.push_back(enc($signed(x), mu));
		@(negedge ref_clk);
		while (lin_in_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
	endtask : send_lin

	task automatic send_chr(input logic [7:0] c, input logic mu);
		chr_in_valid <= 1'b1;
		chr_in_data <= c;
		law_mu_sel <= mu;
		dec_q.push_back(dec(c, mu));
		@(negedge ref_clk);
		while (chr_in_ready !== 1'b1) @(negedge ref_clk);
		@(posedge ref_clk);
	endtask : send_chr

	task automatic drain(input string name);
		lin_in_valid <= 1'b0;
		chr_in_valid <= 1'b0;
		// one edge always passes so the next request is a fresh assignment
		@(posedge ref_clk);
		for (int i = 0; i < 300 && enc_q.size() + dec_q.size() > 0; i++) @(posedge ref_clk);
		check("left_over", 16'(enc_q.size() + dec_q.size()), 16'h0000);
		$display("test %s done", name);
	endtask : drain

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		for (int law = 0; law < 2; law++) begin
			foreach (vals[i]) send_lin(vals[i][13:0], law[0]);
		end
		drain("directed_encode");
		pace <= 2'h1;
		repeat (300) begin
			rnd = lfsr(rnd);
			send_lin(rnd[13:0], rnd[15]);
		end
		drain("random_encode");
		pace <= 2'h2;
		@(posedge ref_clk);
		repeat (5) send_lin(14'h1234, 1'b0);
		lin_in_valid <= 1'b0;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		// fifo holds four plus one staged; nothing more may be taken
		check("lin_in_ready_full", lin_in_ready, 16'h0000);
		pace <= 2'h0;
		drain("fifo_full");
		for (int law = 0; law < 2; law++) begin
			for (int c = 0; c < 256; c++) send_chr(c[7:0], law[0]);
		end
		drain("decode_all");
		finish_test();
	end
endmodule : companding_sample_codec_tb_top

`default_nettype wire
